//--- rtl/sar_adc_consts.vh
// Purpose: offsets, field positions, reset values and counts of the converter control block
// Assumes: 16-bit registers reached over a plain strobe port
// Notes: addresses are register indices on the port
`ifndef SAR_ADC_CONSTS_VH
`define SAR_ADC_CONSTS_VH

`define ADDR_W 5
`define DATA_W 16
`define RES_W 10

// register indices
`define OFF_CONTROL_FIRST 5'h00
`define OFF_CONTROL_SECOND 5'h01
`define OFF_CONTROL_THIRD 5'h02
`define OFF_INPUT_CHANNEL_SELECT 5'h03
`define OFF_PIN_ANALOG_CONFIG 5'h04
`define OFF_SCAN_INPUT_SELECT 5'h05
`define OFF_INT_STATUS 5'h06
`define OFF_INT_MASK 5'h07
`define OFF_RESULT_BASE 5'h10

// conv_control_first fields
`define F1_MODULE_ON 15
`define F1_FORM_HI 9
`define F1_FORM_LO 8
`define F1_TRIG_HI 7
`define F1_TRIG_LO 5
`define F1_SIMULTANEOUS 3
`define F1_AUTO_SAMPLE 2
`define F1_SAMPLE_CONTROL 1
`define F1_DONE 0

// conv_control_second fields
`define F2_REF_HI 15
`define F2_REF_LO 13
`define F2_SCAN_ENABLE 10
`define F2_BUF_HALF 7
`define F2_SAMPLES_PER_INTERRUPT_HI 5
`define F2_SAMPLES_PER_INTERRUPT_LO 2
`define F2_BUF_SPLIT 1
`define F2_ALT_INPUT 0

// conv_control_third fields
`define F3_SAMC_HI 12
`define F3_SAMC_LO 8
`define F3_CLKDIV_HI 5
`define F3_CLKDIV_LO 0

// interrupt status bits
`define INT_SEQUENCE 0
`define INT_CONVERSION 1

// trigger sources
`define TRIG_SOFTWARE 3'h0
`define TRIG_EXTERNAL 3'h1
`define TRIG_TIMER 3'h2
`define TRIG_AUTO 3'h7

// reset values
`define RST_CONTROL_FIRST 16'h0000
`define RST_CONTROL_SECOND 16'h0000
`define RST_CONTROL_THIRD 16'h0000
`define RST_INPUT_CHANNEL_SELECT 16'h0000
`define RST_PIN_ANALOG_CONFIG 16'h0000
`define RST_SCAN_INPUT_SELECT 16'h0000

// write masks of fields that stay fixed while the module is on
`define LOCK_MASK_FIRST 16'h00EC
`define LOCK_MASK_SECOND 16'h003F

// conversion length in conversion-clock periods
`define SAR_TAD_CYCLES 4'hC

`endif

//--- rtl/sar_step.v
// Purpose: successive-approximation engine, one bit decision per conversion-clock tick
// Assumes: comparator input high when the held sample is at or above the trial code
// Notes: twelve ticks per conversion, the last two only settle
`timescale 1ns/1ps
`include "sar_adc_consts.vh"
module sar_step (
    input wire clk_in,
    input wire rst_n_in,
    input wire tick_in,
    input wire start_in,
    input wire abort_in,
    input wire comp_in,
    output reg [`RES_W-1:0] dac_out,
    output reg busy_out,
    output reg done_out,
    output reg [`RES_W-1:0] result_out
);
    reg [3:0] step_reg;
    reg [`RES_W-1:0] mask_reg;

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            step_reg <= 4'h0;
            mask_reg <= 10'h000;
            dac_out <= 10'h000;
            busy_out <= 1'b0;
            done_out <= 1'b0;
            result_out <= 10'h000;
        end else begin
            done_out <= 1'b0;
            if (abort_in) begin
                busy_out <= 1'b0;
                step_reg <= 4'h0;
            end else if (start_in && !busy_out) begin
                busy_out <= 1'b1;
                step_reg <= 4'h0;
                mask_reg <= 10'h200;
                dac_out <= 10'h200;
            end else if (busy_out && tick_in) begin
                // successive approximation: keep or drop the trial bit, then try the next
                if (mask_reg != 10'h000) begin
                    if (!comp_in) begin
                        dac_out <= (dac_out & ~mask_reg) | (mask_reg >> 1);
                    end else begin
                        dac_out <= dac_out | (mask_reg >> 1);
                    end
                    mask_reg <= mask_reg >> 1;
                end
                if (step_reg == `SAR_TAD_CYCLES - 4'h1) begin
                    busy_out <= 1'b0;
                    done_out <= 1'b1;
                    result_out <= dac_out;
                end
                step_reg <= step_reg + 4'h1;
            end
        end
    end
endmodule

//--- rtl/sar_adc_sequencer.v
// Purpose: control logic of a 10-bit successive-approximation converter with 16 inputs
// Assumes: inputs synchronous to ref_clk_in; analog mux, hold amplifiers and comparator outside
// Notes: register port with read data one cycle after the read strobe
//
// What this block does
// - converts the selected input into a 10-bit result by successive approximation
// - routes any of 16 inputs through the mux onto the hold amplifiers
// - software picks supply rails or external reference pins as references
// - converter keeps running while the rest of the device sleeps
// - six 16-bit registers: three control, channel select, pin config, scan select
// - pin config sets analog or digital per pin; scan starts each sequence at input 0, then steps through inputs the scan register picks
// - results held in a 16-word buffer of 10 bits, read as formatted words
// - result buffer is read-only; software writes leave it unchanged
// - setting the sample-control bit starts acquisition once the module is on
// - selected trigger ends acquisition and starts conversion: bit, timer, external or auto sample counter
// - each result is stored; flag and done set after the programmed count
// - samples-per-interrupt selects 1 to 16 sequences per interrupt
// - with trigger source 000, clearing sample-control triggers the conversion
`timescale 1ns/1ps
`include "sar_adc_consts.vh"
module sar_adc_sequencer (
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire [`ADDR_W-1:0] addr_in,
    input wire [`DATA_W-1:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [`DATA_W-1:0] rdata_out,
    input wire ext_trig_in,
    input wire timer_trig_in,
    input wire comp_in,
    output reg [3:0] chan_sel_out,
    output reg sample_hold_out,
    output reg [`RES_W-1:0] dac_code_out,
    output reg [2:0] ref_sel_out,
    output reg [15:0] pin_analog_out,
    output reg irq_out
);
    localparam ST_IDLE = 2'h0;
    localparam ST_SAMPLE = 2'h1;
    localparam ST_CONVERT = 2'h2;

    reg [15:0] control_first_reg;
    reg [15:0] control_second_reg;
    reg [15:0] control_third_reg;
    reg [15:0] input_channel_select_reg;
    reg [15:0] pin_analog_config_reg;
    reg [15:0] scan_input_select_reg;
    reg [1:0] int_status_reg;
    reg [1:0] int_mask_reg;
    reg [`RES_W-1:0] result_buffer_reg [0:15];
    reg [1:0] state_reg;
    reg [5:0] tad_cnt_reg;
    reg [4:0] samc_cnt_reg;
    reg [3:0] wr_idx_reg;
    reg [3:0] seq_cnt_reg;
    reg half_reg;
    reg alt_phase_reg;
    reg [3:0] scan_pos_reg;
    reg [15:0] rdata_next;
    reg [3:0] scan_next;
    reg trigger_next;
    integer i;

    wire module_on = control_first_reg[`F1_MODULE_ON];
    wire sample_control = control_first_reg[`F1_SAMPLE_CONTROL];
    wire [2:0] trigger_source_sel = control_first_reg[`F1_TRIG_HI:`F1_TRIG_LO];
    wire [1:0] form_sel = control_first_reg[`F1_FORM_HI:`F1_FORM_LO];
    wire auto_sample_enable = control_first_reg[`F1_AUTO_SAMPLE];
    wire [3:0] samples_per_interrupt = control_second_reg[`F2_SAMPLES_PER_INTERRUPT_HI:`F2_SAMPLES_PER_INTERRUPT_LO];
    wire buffer_split_mode = control_second_reg[`F2_BUF_SPLIT];
    wire alternate_input_sel = control_second_reg[`F2_ALT_INPUT];
    wire scan_enable = control_second_reg[`F2_SCAN_ENABLE];
    wire [4:0] samc = control_third_reg[`F3_SAMC_HI:`F3_SAMC_LO];
    wire [5:0] clk_div = control_third_reg[`F3_CLKDIV_HI:`F3_CLKDIV_LO];
    wire [3:0] sel = addr_in[3:0];

    wire wr_first = wr_in && (addr_in == `OFF_CONTROL_FIRST);
    wire wr_second = wr_in && (addr_in == `OFF_CONTROL_SECOND);
    // software clearing sample-control while sampling
    wire sw_clear = wr_first && sample_control && !wdata_in[`F1_SAMPLE_CONTROL];
    wire sw_set = wr_first && !sample_control && wdata_in[`F1_SAMPLE_CONTROL];

    // conversion clock: one-cycle tick every clk_div+1 system clocks
    wire tad_tick = (tad_cnt_reg == clk_div);

    wire sar_busy;
    wire sar_done;
    wire [`RES_W-1:0] sar_result;
    wire [`RES_W-1:0] sar_dac;
    wire conv_start = (state_reg == ST_SAMPLE) && trigger_next;
    wire seq_end = sar_done && (seq_cnt_reg == samples_per_interrupt);

    sar_step u_sar (
        .clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .tick_in(tad_tick && (dac_code_out == sar_dac)),
        .start_in(conv_start),
        .abort_in(!module_on),
        .comp_in(comp_in),
        .dac_out(sar_dac),
        .busy_out(sar_busy),
        .done_out(sar_done),
        .result_out(sar_result)
    );

    // trigger selection
    always @* begin
        case (trigger_source_sel)
            `TRIG_SOFTWARE: trigger_next = sw_clear;
            `TRIG_EXTERNAL: trigger_next = ext_trig_in;
            `TRIG_TIMER: trigger_next = timer_trig_in;
            `TRIG_AUTO: trigger_next = tad_tick && (samc_cnt_reg >= samc) && (samc != 5'h00);
            default: trigger_next = 1'b0;
        endcase
    end

    // next scanned input: lowest selected input above the current one, else lowest overall
    always @* begin
        scan_next = scan_pos_reg;
        for (i = 15; i >= 0; i = i - 1) begin
            if (scan_input_select_reg[i]) begin
                scan_next = i[3:0];
            end
        end
        for (i = 15; i >= 0; i = i - 1) begin
            if (scan_input_select_reg[i] && (i[3:0] > scan_pos_reg)) begin
                scan_next = i[3:0];
            end
        end
    end

    // read data, formatted result words
    always @* begin
        rdata_next = 16'h0000;
        if (addr_in[4]) begin
            case (form_sel)
                2'h0: rdata_next = {6'h00, result_buffer_reg[sel]};
                2'h1: rdata_next = {{7{~result_buffer_reg[sel][9]}}, result_buffer_reg[sel][8:0]};
                2'h2: rdata_next = {result_buffer_reg[sel], 6'h00};
                default: rdata_next = {~result_buffer_reg[sel][9], result_buffer_reg[sel][8:0], 6'h00};
            endcase
        end else begin
            case (addr_in)
                `OFF_CONTROL_FIRST: rdata_next = control_first_reg;
                `OFF_CONTROL_SECOND: rdata_next = {control_second_reg[15:8], half_reg, control_second_reg[6:0]};
                `OFF_CONTROL_THIRD: rdata_next = control_third_reg;
                `OFF_INPUT_CHANNEL_SELECT: rdata_next = input_channel_select_reg;
                `OFF_PIN_ANALOG_CONFIG: rdata_next = pin_analog_config_reg;
                `OFF_SCAN_INPUT_SELECT: rdata_next = scan_input_select_reg;
                `OFF_INT_STATUS: rdata_next = {14'h0000, int_status_reg};
                `OFF_INT_MASK: rdata_next = {14'h0000, int_mask_reg};
                default: rdata_next = 16'h0000;
            endcase
        end
    end

    // register file and sequencer; no sleep gating, so conversion runs on in sleep
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            control_first_reg <= `RST_CONTROL_FIRST;
            control_second_reg <= `RST_CONTROL_SECOND;
            control_third_reg <= `RST_CONTROL_THIRD;
            input_channel_select_reg <= `RST_INPUT_CHANNEL_SELECT;
            pin_analog_config_reg <= `RST_PIN_ANALOG_CONFIG;
            scan_input_select_reg <= `RST_SCAN_INPUT_SELECT;
            int_status_reg <= 2'h0;
            int_mask_reg <= 2'h0;
            state_reg <= ST_IDLE;
            tad_cnt_reg <= 6'h00;
            samc_cnt_reg <= 5'h00;
            wr_idx_reg <= 4'h0;
            seq_cnt_reg <= 4'h0;
            half_reg <= 1'b0;
            alt_phase_reg <= 1'b0;
            scan_pos_reg <= 4'h0;
            for (i = 0; i < 16; i = i + 1) begin
                result_buffer_reg[i] <= 10'h000;
            end
        end else begin
            // software writes; locked fields hold while the module is on
            if (wr_first) begin
                if (module_on) begin
                    control_first_reg <= (control_first_reg & `LOCK_MASK_FIRST) | (wdata_in & ~`LOCK_MASK_FIRST);
                end else begin
                    control_first_reg <= wdata_in;
                end
            end
            if (wr_second) begin
                if (module_on) begin
                    control_second_reg <= (control_second_reg & `LOCK_MASK_SECOND) | (wdata_in & ~`LOCK_MASK_SECOND);
                end else begin
                    control_second_reg <= wdata_in;
                end
            end
            if (wr_in && !module_on) begin
                if (addr_in == `OFF_CONTROL_THIRD) begin
                    control_third_reg <= wdata_in;
                end
                if (addr_in == `OFF_SCAN_INPUT_SELECT) begin
                    scan_input_select_reg <= wdata_in;
                end
            end
            if (wr_in && (addr_in == `OFF_INPUT_CHANNEL_SELECT)) begin
                input_channel_select_reg <= wdata_in;
            end
            if (wr_in && (addr_in == `OFF_PIN_ANALOG_CONFIG)) begin
                pin_analog_config_reg <= wdata_in;
            end
            if (wr_in && (addr_in == `OFF_INT_MASK)) begin
                int_mask_reg <= wdata_in[1:0];
            end
            // write-one-to-clear; a same-cycle event wins
            int_status_reg <= (int_status_reg & ~((wr_in && (addr_in == `OFF_INT_STATUS)) ? wdata_in[1:0] : 2'h0))
                | {sar_done, seq_end};

            tad_cnt_reg <= tad_tick ? 6'h00 : tad_cnt_reg + 6'h01;

            case (state_reg)
                ST_IDLE: begin
                    samc_cnt_reg <= 5'h00;
                    if (module_on && (sw_set || (sample_control && !wr_first))) begin
                        state_reg <= ST_SAMPLE;
                    end
                end
                ST_SAMPLE: begin
                    if (tad_tick && (samc_cnt_reg != 5'h1F)) begin
                        samc_cnt_reg <= samc_cnt_reg + 5'h01;
                    end
                    if (!module_on) begin
                        state_reg <= ST_IDLE;
                    end else if (trigger_next) begin
                        state_reg <= ST_CONVERT;
                        control_first_reg[`F1_SAMPLE_CONTROL] <= 1'b0;
                        control_first_reg[`F1_DONE] <= 1'b0;
                    end
                end
                ST_CONVERT: begin
                    if (!module_on) begin
                        state_reg <= ST_IDLE;
                    end else if (sar_done) begin
                        result_buffer_reg[wr_idx_reg] <= sar_result;
                        alt_phase_reg <= ~alt_phase_reg;
                        if (scan_enable) begin
                            scan_pos_reg <= scan_next;
                        end
                        if (seq_end) begin
                            control_first_reg[`F1_DONE] <= 1'b1;
                            seq_cnt_reg <= 4'h0;
                            alt_phase_reg <= 1'b0;
                            scan_pos_reg <= 4'h0;
                            // restart at the first entry, or the other half when split
                            half_reg <= buffer_split_mode & ~half_reg;
                            wr_idx_reg <= (buffer_split_mode && !half_reg) ? 4'h8 : 4'h0;
                        end else begin
                            seq_cnt_reg <= seq_cnt_reg + 4'h1;
                            wr_idx_reg <= wr_idx_reg + 4'h1;
                        end
                        if (auto_sample_enable) begin
                            control_first_reg[`F1_SAMPLE_CONTROL] <= 1'b1;
                            state_reg <= ST_SAMPLE;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase

            if (!module_on) begin
                seq_cnt_reg <= 4'h0;
                wr_idx_reg <= 4'h0;
                half_reg <= 1'b0;
                alt_phase_reg <= 1'b0;
                scan_pos_reg <= 4'h0;
            end
        end
    end

    // registered pin-facing outputs, read data and interrupt line
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_out <= 16'h0000;
            chan_sel_out <= 4'h0;
            sample_hold_out <= 1'b0;
            dac_code_out <= 10'h000;
            ref_sel_out <= 3'h0;
            pin_analog_out <= 16'h0000;
            irq_out <= 1'b0;
        end else begin
            rdata_out <= rd_in ? rdata_next : 16'h0000;
            if (scan_enable) begin
                chan_sel_out <= scan_pos_reg;
            end else if (alternate_input_sel && alt_phase_reg) begin
                chan_sel_out <= input_channel_select_reg[11:8];
            end else begin
                chan_sel_out <= input_channel_select_reg[3:0];
            end
            sample_hold_out <= (state_reg == ST_SAMPLE) && module_on;
            dac_code_out <= sar_busy ? sar_dac : 10'h000;
            ref_sel_out <= control_second_reg[`F2_REF_HI:`F2_REF_LO];
            pin_analog_out <= ~pin_analog_config_reg;
            irq_out <= |(int_status_reg & int_mask_reg);
        end
    end
endmodule

//--- bench/sar_adc_chk.sv
// Purpose: port-level property checks of the converter control block
// Assumes: one clock, asynchronous active-low reset
// Notes: tracks module_on and trigger_source_sel to qualify the trigger checks
`timescale 1ns/1ps
`include "sar_adc_consts.vh"
module sar_adc_chk (
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire [`ADDR_W-1:0] addr_in,
    input wire [`DATA_W-1:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire [`DATA_W-1:0] rdata_out,
    input wire ext_trig_in,
    input wire timer_trig_in,
    input wire [`RES_W-1:0] dac_code_out,
    input wire sample_hold_out,
    input wire [2:0] ref_sel_out,
    input wire [15:0] pin_analog_out,
    input wire irq_out
);
    reg on_reg;
    reg [2:0] trig_reg;
    wire wr0 = wr_in && addr_in == `OFF_CONTROL_FIRST;
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            on_reg <= 1'b0;
            trig_reg <= 3'h0;
        end else if (wr0) begin
            on_reg <= wdata_in[`F1_MODULE_ON];
            if (!on_reg) begin
                trig_reg <= wdata_in[`F1_TRIG_HI:`F1_TRIG_LO];
            end
        end
    end
    default clocking dc @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_start;
        wr0 && on_reg && wdata_in[`F1_MODULE_ON] && wdata_in[`F1_SAMPLE_CONTROL];
    endsequence
    sequence s_sw_clear;
        sample_hold_out && on_reg && trig_reg == `TRIG_SOFTWARE && wr0 && wdata_in[15] && !wdata_in[1];
    endsequence
    sequence s_mask_off;
        (wr_in && addr_in == `OFF_INT_MASK && wdata_in == 16'h0000) ##1 !(wr_in && addr_in == `OFF_INT_MASK);
    endsequence
    chk_read_slot: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
        else $error("read data outside its slot");
    chk_sample_start: assert property (s_start |-> ##2 sample_hold_out)
        else $error("sampling did not start");
    chk_sw_trigger: assert property (s_sw_clear |-> ##[1:3] !sample_hold_out)
        else $error("clearing sample control did not end sampling");
    chk_ext_trigger: assert property (sample_hold_out && trig_reg == `TRIG_EXTERNAL && ext_trig_in
        |-> ##[1:4] !sample_hold_out) else $error("external trigger ignored");
    chk_timer_trigger: assert property (sample_hold_out && trig_reg == `TRIG_TIMER && timer_trig_in
        |-> ##[1:4] !sample_hold_out) else $error("timer trigger ignored");
    chk_first_trial: assert property ($fell(sample_hold_out) && on_reg |-> ##[1:12] dac_code_out == 10'h200)
        else $error("conversion did not begin at mid code");
    chk_ref_follow: assert property (wr_in && addr_in == `OFF_CONTROL_SECOND
        |-> ##2 ref_sel_out == $past(wdata_in[15:13], 2)) else $error("reference select mismatch");
    chk_pin_map: assert property (wr_in && addr_in == `OFF_PIN_ANALOG_CONFIG
        |-> ##2 pin_analog_out == ~$past(wdata_in, 2)) else $error("pin analog map mismatch");
    chk_irq_masked: assert property (s_mask_off |-> ##1 !irq_out)
        else $error("interrupt high while masked");
endmodule
bind sar_adc_sequencer sar_adc_chk sar_adc_chk_i (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .ext_trig_in(ext_trig_in),
    .timer_trig_in(timer_trig_in), .dac_code_out(dac_code_out), .sample_hold_out(sample_hold_out),
    .ref_sel_out(ref_sel_out), .pin_analog_out(pin_analog_out), .irq_out(irq_out));

//--- bench/adc_front_end.sv
// Purpose: analog mux, hold amplifier and comparator seen by the block
// Assumes: levels given per input as 10-bit codes
// Notes: tracks while sample_hold_in is high, holds otherwise
`timescale 1ns/1ps
module adc_front_end (
    input wire ref_clk_in,
    input wire [159:0] level_in,
    input wire [3:0] chan_sel_in,
    input wire sample_hold_in,
    input wire [9:0] dac_code_in,
    output wire comp_out
);
    reg [9:0] held_reg = 10'h000;
    always @(posedge ref_clk_in) begin
        if (sample_hold_in) begin
            held_reg <= level_in[chan_sel_in * 10 +: 10];
        end
    end
    assign comp_out = held_reg >= dac_code_in;
endmodule

//--- bench/sar_adc_sequencer_tb_top.sv
// Purpose: self-checking bench of the converter control block
// Assumes: front-end model answers the comparator
// Notes: random levels, channels and clock divider from a fixed-seed shift register
`timescale 1ns/1ps
`include "sar_adc_consts.vh"
module sar_adc_sequencer_tb_top;
    reg ref_clk_in = 1'b0;
    reg rst_n_in = 1'b0;
    reg [`ADDR_W-1:0] addr_in = 5'h00;
    reg [`DATA_W-1:0] wdata_in = 16'h0000;
    reg wr_in = 1'b0;
    reg rd_in = 1'b0;
    reg ext_trig_in = 1'b0;
    reg timer_trig_in = 1'b0;
    reg [159:0] level = 160'h0;
    wire comp;
    wire [15:0] rdata_out;
    wire [3:0] chan_sel_out;
    wire sample_hold_out;
    wire [9:0] dac_code_out;
    wire [2:0] ref_sel_out;
    wire [15:0] pin_analog_out;
    wire irq_out;
    integer bad_count = 0;
    integer checks = 0;
    integer cycles = 0;
    integer cfg, rep, k, n, ch;
    reg [31:0] seed = 32'hBF6D6839;
    reg [15:0] rv, base;
    reg [2:0] trig;
    reg [1:0] fmt;
    reg [9:0] lv [0:15];
    sar_adc_sequencer sar_adc_sequencer_i (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .ext_trig_in(ext_trig_in),
        .timer_trig_in(timer_trig_in), .comp_in(comp), .chan_sel_out(chan_sel_out), .sample_hold_out(sample_hold_out),
        .dac_code_out(dac_code_out), .ref_sel_out(ref_sel_out), .pin_analog_out(pin_analog_out), .irq_out(irq_out));
    adc_front_end adc_front_end_i (.ref_clk_in(ref_clk_in), .level_in(level), .chan_sel_in(chan_sel_out),
        .sample_hold_in(sample_hold_out), .dac_code_in(dac_code_out), .comp_out(comp));
    function [15:0] fmt_word(input [9:0] r, input [1:0] f);
        case (f)
            2'h0: fmt_word = {6'h00, r};
            2'h1: fmt_word = {{7{~r[9]}}, r[8:0]};
            2'h2: fmt_word = {r, 6'h00};
            default: fmt_word = {~r[9], r[8:0], 6'h00};
        endcase
    endfunction
    task next_rand;
        begin
            seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
            rv = seed[15:0];
        end
    endtask
    task close_out;
        begin
            $display("checks %0d bad_count %0d", checks, bad_count);
            if (bad_count == 0 && checks > 0) begin
                $display("STATUS OK");
            end else begin
                $display("STATUS NOT OK");
            end
            $finish;
        end
    endtask
    task cmp16(input [15:0] got, input [15:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("FAIL %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task cmp_bit(input got, input exp);
        begin
            cmp16({15'h0000, got}, {15'h0000, exp});
        end
    endtask
    task wr(input [4:0] a, input [15:0] d);
        begin
            @(posedge ref_clk_in);
            wr_in <= 1'b1;
            addr_in <= a;
            wdata_in <= d;
            @(posedge ref_clk_in);
            wr_in <= 1'b0;
        end
    endtask
    task rd(input [4:0] a, output [15:0] d);
        begin
            @(posedge ref_clk_in);
            rd_in <= 1'b1;
            addr_in <= a;
            @(posedge ref_clk_in);
            rd_in <= 1'b0;
            #1 d = rdata_out;
        end
    endtask
    task chk_reg(input [4:0] a, input [15:0] m, input [15:0] e);
        reg [15:0] t;
        begin
            rd(a, t);
            cmp16(t & m, e);
        end
    endtask
    task wait_conv;
        integer i;
        reg [15:0] t;
        begin
            t = 16'h0000;
            for (i = 0; i < 100 && t[`INT_CONVERSION] !== 1'b1; i = i + 1) begin
                rd(`OFF_INT_STATUS, t);
            end
            cmp_bit(t[`INT_CONVERSION], 1'b1);
            wr(`OFF_INT_STATUS, 16'h0002);
        end
    endtask
    initial begin
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    always @(posedge ref_clk_in) begin
        cycles = cycles + 1;
        if (cycles == 60000) begin
            bad_count = bad_count + 1;
            $display("FAIL %0t run too long", $time);
            close_out;
        end
    end
    initial begin
        repeat (16) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        @(posedge ref_clk_in);
        #1 cmp16(pin_analog_out, 16'hFFFF);
        for (k = 0; k < 6; k = k + 1) begin
            chk_reg(k[4:0], 16'hFFFF, 16'h0000);
        end
        wr(5'h08, 16'hFFFF);
        chk_reg(5'h08, 16'hFFFF, 16'h0000);
        next_rand;
        wr(`OFF_SCAN_INPUT_SELECT, rv);
        chk_reg(`OFF_SCAN_INPUT_SELECT, 16'hFFFF, rv);
        wr(`OFF_PIN_ANALOG_CONFIG, ~rv);
        for (cfg = 0; cfg < 4; cfg = cfg + 1) begin
            trig = (cfg == 1) ? `TRIG_EXTERNAL : (cfg == 2) ? `TRIG_TIMER : `TRIG_SOFTWARE;
            n = (cfg == 2) ? 15 : cfg;
            fmt = cfg[1:0];
            base = {6'h00, fmt, trig, 5'h00};
            next_rand;
            wr(`OFF_CONTROL_FIRST, base);
            wr(`OFF_CONTROL_SECOND, {rv[15:13], 7'h00, n[3:0], 2'h0});
            wr(`OFF_CONTROL_THIRD, {15'h0000, rv[0]});
            wr(`OFF_INT_MASK, (cfg == 3) ? 16'h0000 : 16'h0001);
            wr(`OFF_CONTROL_FIRST, base | 16'h8000);
            for (rep = 0; rep < 2; rep = rep + 1) begin
                for (k = 0; k <= n; k = k + 1) begin
                    next_rand;
                    ch = rv[3:0];
                    lv[k] = rv[13:4];
                    level[ch * 10 +: 10] = rv[13:4];
                    wr(`OFF_INPUT_CHANNEL_SELECT, rv & 16'h000F);
                    wr(`OFF_CONTROL_FIRST, base | 16'h8002);
                    repeat (2 + rv[15:14]) @(posedge ref_clk_in);
                    if (trig == `TRIG_SOFTWARE) begin
                        wr(`OFF_CONTROL_FIRST, base | 16'h8000);
                    end else begin
                        ext_trig_in <= (trig == `TRIG_EXTERNAL);
                        timer_trig_in <= (trig == `TRIG_TIMER);
                        repeat (2) @(posedge ref_clk_in);
                        ext_trig_in <= 1'b0;
                        timer_trig_in <= 1'b0;
                    end
                    wait_conv;
                    if (k < n) begin
                        chk_reg(`OFF_CONTROL_FIRST, 16'h8001, 16'h8000);
                        cmp_bit(irq_out, 1'b0);
                    end
                end
                cmp_bit(irq_out, cfg != 3);
                chk_reg(`OFF_CONTROL_FIRST, 16'h8001, 16'h8001);
                chk_reg(`OFF_INT_STATUS, 16'h0001, 16'h0001);
                for (k = 0; k <= n; k = k + 1) begin
                    chk_reg(`OFF_RESULT_BASE + k[4:0], 16'hFFFF, fmt_word(lv[k], fmt));
                end
                wr(`OFF_RESULT_BASE, 16'h5A5A);
                chk_reg(`OFF_RESULT_BASE, 16'hFFFF, fmt_word(lv[0], fmt));
                wr(`OFF_INT_STATUS, 16'h0001);
                @(posedge ref_clk_in);
                #1 cmp_bit(irq_out, 1'b0);
            end
        end
        close_out;
    end
endmodule
